//--- design/serial_port_regs.svh
// Register map, field positions, reset values and timing counts
// Assumes inclusion by bare name from every design file but the package
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// ----------------------------------------
// Byte addresses
// ----------------------------------------
`define ADDR_CH0_FMT 8'h00
`define ADDR_CH1_FMT 8'h04
`define ADDR_CH2_FMT 8'h08
`define ADDR_HDR 8'h0c
`define ADDR_TERM 8'h10
`define ADDR_CTRL 8'h14
`define ADDR_CH0_MODE 8'h18
`define ADDR_CH1_MODE 8'h1c
`define ADDR_CH2_MODE 8'h20
`define ADDR_TXDATA 8'h24
`define ADDR_STATUS 8'h28
`define ADDR_ERR 8'h2c
`define ADDR_LEGACY_FMT 8'h30

// ----------------------------------------
// Frame format fields
// ----------------------------------------
`define FMT_LEN8 0
`define FMT_PAR_EN 1
`define FMT_PAR_EVEN 2
`define FMT_STOP2 3
`define FMT_BAUD_LO 4
`define FMT_BAUD_HI 7
`define FMT_HDR 8
`define FMT_TERM 9
`define FMT_RSVD_LO 13
`define FMT_RSVD_HI 15

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_RUN 0
`define CTRL_FFEN_LO 1
`define CTRL_MDROP_LO 4
`define CTRL_LINK_LO 7

// ----------------------------------------
// Reset values and characters
// ----------------------------------------
`define HDR_RST 8'h02
`define TERM_RST 8'h03
`define NAK_CHAR 8'h15
`define FMT_PROG_DEFAULT 16'h0086

// ----------------------------------------
// Baud codes and rates
// ----------------------------------------
`define BAUD_300 4'h3
`define BAUD_600 4'h4
`define BAUD_1200 4'h5
`define BAUD_2400 4'h6
`define BAUD_4800 4'h7
`define BAUD_9600 4'h8
`define BAUD_19200 4'h9
`define BAUD_38400 4'ha
`define RATE_300 300
`define RATE_600 600
`define RATE_1200 1200
`define RATE_2400 2400
`define RATE_4800 4800
`define RATE_9600 9600
`define RATE_19200 19200
`define RATE_38400 38400

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define CLK_HZ (1000000000 / `CLK_PERIOD_NS)

`endif

//--- design/serial_port_pkg.sv
// Types shared by the serial port top and its character transmitter
// Assumes the register header is compiled alongside
package serial_port_pkg;

    typedef enum logic [1:0] {mode_idle, mode_free, mode_prog, mode_link} mode_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [2:0][15:0] fmt;
        logic [7:0] hdr;
        logic [7:0] term;
        logic [9:0] ctrl;
        mode_t [2:0] mode;
        logic [2:0][3:0] pend;
        logic [2:0][7:0] dat;
        logic [2:0] start;
        logic [2:0][7:0] chr;
        logic [2:0][15:0] txfmt;
        logic [2:0] err_rej;
        logic [2:0] err_nak;
    } port_st_t;

    typedef struct packed {
        logic busy;
        logic txd;
        logic [3:0] left;
        logic [11:0] sh;
        logic [19:0] div;
        logic [19:0] cnt;
    } tx_st_t;

endpackage

//--- design/serial_char_tx.sv
// One asynchronous character transmitter, framed by a format word
// Assumes start is a one-cycle pulse given only while busy is low
`timescale 1ns/1ps
`include "serial_port_regs.svh"

module serial_char_tx #(
    parameter int unsigned clk_hz = `CLK_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [7:0] chr,
    input wire logic [15:0] fmt,
    output logic txd,
    output logic busy
);

    serial_port_pkg::tx_st_t s_ff;
    serial_port_pkg::tx_st_t nxt_s;

    // ----------------------------------------
    // Baud table
    // ----------------------------------------
    function automatic logic [19:0] baud_div(input logic [3:0] code);
        case (code)
            `BAUD_300: baud_div = 20'(clk_hz / `RATE_300);
            `BAUD_600: baud_div = 20'(clk_hz / `RATE_600);
            `BAUD_1200: baud_div = 20'(clk_hz / `RATE_1200);
            `BAUD_2400: baud_div = 20'(clk_hz / `RATE_2400);
            `BAUD_4800: baud_div = 20'(clk_hz / `RATE_4800);
            `BAUD_9600: baud_div = 20'(clk_hz / `RATE_9600);
            `BAUD_19200: baud_div = 20'(clk_hz / `RATE_19200);
            `BAUD_38400: baud_div = 20'(clk_hz / `RATE_38400);
            default: baud_div = 20'h0;
        endcase
    endfunction

    function automatic serial_port_pkg::tx_st_t st_reset();
        serial_port_pkg::tx_st_t r;
        r = '0;
        r.txd = 1'b1;
        return r;
    endfunction

    // ----------------------------------------
    // Framing and shifting
    // ----------------------------------------
    always_comb begin
        logic [19:0] d;
        logic [7:0] used;
        logic [11:0] f;
        logic [3:0] len;
        logic par;
        nxt_s = s_ff;
        d = baud_div(fmt[`FMT_BAUD_HI:`FMT_BAUD_LO]);
        used = fmt[`FMT_LEN8] ? chr : {1'b0, chr[6:0]};
        // Odd parity sets the bit when the data count is even
        par = fmt[`FMT_PAR_EVEN] ? ^used : ~^used;
        f = 12'hfff;
        f[0] = 1'b0;
        f[7:1] = used[6:0];
        if (fmt[`FMT_LEN8]) begin
            f[8] = used[7];
        end
        if (fmt[`FMT_PAR_EN]) begin
            f[fmt[`FMT_LEN8] ? 9 : 8] = par;
        end
        len = 4'h9 + {3'h0, fmt[`FMT_LEN8]} + {3'h0, fmt[`FMT_PAR_EN]}
            + {3'h0, fmt[`FMT_STOP2]};
        if (!s_ff.busy) begin
            // An invalid baud code drops the character
            if (start && d != 20'h0) begin
                nxt_s.busy = 1'b1;
                nxt_s.txd = f[0];
                nxt_s.sh = {1'b1, f[11:1]};
                nxt_s.left = len - 4'h1;
                nxt_s.div = d;
                nxt_s.cnt = d - 20'h1;
            end
        end else if (s_ff.cnt != 20'h0) begin
            nxt_s.cnt = s_ff.cnt - 20'h1;
        end else if (s_ff.left == 4'h0) begin
            nxt_s.busy = 1'b0;
            nxt_s.txd = 1'b1;
        end else begin
            nxt_s.txd = s_ff.sh[0];
            nxt_s.sh = {1'b1, s_ff.sh[11:1]};
            nxt_s.left = s_ff.left - 4'h1;
            nxt_s.cnt = s_ff.div - 20'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= st_reset();
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign txd = s_ff.txd;
    assign busy = s_ff.busy;

endmodule

//--- design/serial_port_mode_switch.sv
// Three-channel serial port with free-format, programming and link modes
// Assumes an APB master on pclk and a receive path flagging foreign frames
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "serial_port_regs.svh"

module serial_port_mode_switch #(
    parameter int unsigned clk_hz = `CLK_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] foreign_frame,
    output logic [2:0] txd
);

    serial_port_pkg::port_st_t s_ff;
    serial_port_pkg::port_st_t nxt_s;
    logic [2:0] tx_busy;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic serial_port_pkg::port_st_t st_reset();
        serial_port_pkg::port_st_t r;
        r = '0;
        r.hdr = `HDR_RST;
        r.term = `TERM_RST;
        return r;
    endfunction

    // Free-format needs a valid baud code and the upper bits clear
    function automatic logic fmt_suitable(input logic [15:0] f);
        logic [3:0] b;
        b = f[`FMT_BAUD_HI:`FMT_BAUD_LO];
        fmt_suitable = b >= `BAUD_300 && b <= `BAUD_38400
            && f[`FMT_RSVD_HI:`FMT_RSVD_LO] == 3'h0;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic run;
        logic acc;
        logic wr;
        logic hit;
        logic [31:0] rdv;
        logic [1:0] ch;
        logic ffen;
        logic mdrop;
        logic linksel;
        serial_port_pkg::mode_t nm;
        nxt_s = s_ff;
        run = s_ff.ctrl[`CTRL_RUN];
        acc = psel && penable && !s_ff.pready;
        wr = psel && penable && pwrite && s_ff.pready;
        ch = pwdata[9:8];
        ffen = 1'b0;
        mdrop = 1'b0;
        linksel = 1'b0;
        nm = serial_port_pkg::mode_idle;
        nxt_s.start = 3'h0;

        // ----------------------------------------
        // Read decode
        // ----------------------------------------
        hit = 1'b1;
        rdv = 32'h0;
        case (paddr)
            `ADDR_CH0_FMT: begin
                rdv = {16'h0, s_ff.fmt[0]};
            end
            `ADDR_CH1_FMT, `ADDR_LEGACY_FMT: begin
                rdv = {16'h0, s_ff.fmt[1]};
            end
            `ADDR_CH2_FMT: begin
                rdv = {16'h0, s_ff.fmt[2]};
            end
            `ADDR_HDR: begin
                rdv = {24'h0, s_ff.hdr};
            end
            `ADDR_TERM: begin
                rdv = {24'h0, s_ff.term};
            end
            `ADDR_CTRL: begin
                rdv = {22'h0, s_ff.ctrl};
            end
            `ADDR_CH0_MODE: begin
                rdv = {30'h0, s_ff.mode[0]};
            end
            `ADDR_CH1_MODE: begin
                rdv = {30'h0, s_ff.mode[1]};
            end
            `ADDR_CH2_MODE: begin
                rdv = {30'h0, s_ff.mode[2]};
            end
            `ADDR_TXDATA: begin
                rdv = 32'h0;
            end
            `ADDR_STATUS: begin
                rdv = {26'h0, s_ff.pend[2] != 4'h0, s_ff.pend[1] != 4'h0,
                    s_ff.pend[0] != 4'h0, tx_busy};
            end
            `ADDR_ERR: begin
                rdv = {26'h0, s_ff.err_nak, s_ff.err_rej};
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        // ----------------------------------------
        // APB answer, one wait state
        // ----------------------------------------
        nxt_s.pready = acc;
        nxt_s.pslverr = acc && !hit;
        if (acc) begin
            nxt_s.prdata = pwrite ? 32'h0 : rdv;
        end

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (wr && hit) begin
            case (paddr)
                `ADDR_CH0_FMT: begin
                    nxt_s.fmt[0] = pwdata[15:0];
                end
                `ADDR_CH1_FMT, `ADDR_LEGACY_FMT: begin
                    nxt_s.fmt[1] = pwdata[15:0];
                end
                `ADDR_CH2_FMT: begin
                    nxt_s.fmt[2] = pwdata[15:0];
                end
                `ADDR_HDR: begin
                    nxt_s.hdr = pwdata[7:0];
                end
                `ADDR_TERM: begin
                    nxt_s.term = pwdata[7:0];
                end
                `ADDR_CTRL: begin
                    nxt_s.ctrl = pwdata[9:0];
                end
                `ADDR_TXDATA: begin
                    // One message per channel at a time; extras are refused
                    if (ch != 2'h3 && s_ff.mode[ch] == serial_port_pkg::mode_free
                        && s_ff.pend[ch] == 4'h0) begin
                        nxt_s.dat[ch] = pwdata[7:0];
                        nxt_s.pend[ch] = {s_ff.fmt[ch][`FMT_TERM], 1'b1,
                            s_ff.fmt[ch][`FMT_HDR], 1'b0};
                    end else if (ch != 2'h3) begin
                        nxt_s.err_rej[ch] = 1'b1;
                    end
                end
                `ADDR_ERR: begin
                    nxt_s.err_rej = s_ff.err_rej & ~pwdata[2:0];
                    nxt_s.err_nak = s_ff.err_nak & ~pwdata[5:3];
                end
                default: begin
                end
            endcase
        end

        // ----------------------------------------
        // Per-channel mode and message sequencing
        // ----------------------------------------
        for (int i = 0; i < 3; i++) begin
            ffen = s_ff.ctrl[`CTRL_FFEN_LO + i];
            mdrop = s_ff.ctrl[`CTRL_MDROP_LO + i];
            linksel = s_ff.ctrl[`CTRL_LINK_LO + i];
            // Free-format only starts from a format written beforehand
            if (run && ffen && fmt_suitable(s_ff.fmt[i])) begin
                nm = serial_port_pkg::mode_free;
            end else if (s_ff.fmt[i] == 16'h0) begin
                nm = linksel ? serial_port_pkg::mode_link
                    : serial_port_pkg::mode_prog;
            end else if (!run && fmt_suitable(s_ff.fmt[i])) begin
                if (!linksel) begin
                    nm = serial_port_pkg::mode_prog;
                end else if (mdrop) begin
                    nm = serial_port_pkg::mode_idle;
                end else begin
                    nm = serial_port_pkg::mode_link;
                end
            end else begin
                nm = serial_port_pkg::mode_idle;
            end
            nxt_s.mode[i] = nm;

            // Leaving free-format drops an unfinished message
            if (nm != serial_port_pkg::mode_free) begin
                nxt_s.pend[i][3:1] = 3'h0;
            end

            // Programming framing uses FMT_PROG_DEFAULT while the format word is zero, else the format word
            if (s_ff.mode[i] == serial_port_pkg::mode_prog && s_ff.fmt[i] == 16'h0) begin
                nxt_s.txfmt[i] = `FMT_PROG_DEFAULT;
            end else begin
                nxt_s.txfmt[i] = s_ff.fmt[i];
            end

            if (!tx_busy[i] && !s_ff.start[i] && s_ff.pend[i] != 4'h0) begin
                nxt_s.start[i] = 1'b1;
                if (s_ff.pend[i][0]) begin
                    nxt_s.chr[i] = `NAK_CHAR;
                    nxt_s.pend[i][0] = 1'b0;
                end else if (s_ff.pend[i][1]) begin
                    nxt_s.chr[i] = s_ff.hdr;
                    nxt_s.pend[i][1] = 1'b0;
                end else if (s_ff.pend[i][2]) begin
                    nxt_s.chr[i] = s_ff.dat[i];
                    nxt_s.pend[i][2] = 1'b0;
                end else begin
                    nxt_s.chr[i] = s_ff.term;
                    nxt_s.pend[i][3] = 1'b0;
                end
            end

            // A foreign frame in programming mode that meets a pending NAK not starting that cycle sets err_nak; both share the one NAK
            if (foreign_frame[i] && s_ff.mode[i] == serial_port_pkg::mode_prog) begin
                if (s_ff.pend[i][0] && nxt_s.pend[i][0]) begin
                    nxt_s.err_nak[i] = 1'b1;
                end
                nxt_s.pend[i][0] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= st_reset();
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------
    // Transmitters
    // ----------------------------------------
    for (genvar g = 0; g < 3; g++) begin : gen_tx
        serial_char_tx #(
            .clk_hz(clk_hz)
        ) u_tx (
            .pclk(pclk),
            .presetn(presetn),
            .start(s_ff.start[g]),
            .chr(s_ff.chr[g]),
            .fmt(s_ff.txfmt[g]),
            .txd(txd[g]),
            .busy(tx_busy[g])
        );
    end

    assign prdata = s_ff.prdata;
    assign pready = s_ff.pready;
    assign pslverr = s_ff.pslverr;

endmodule

//--- testbench/serial_port_mode_switch_chk.sv
// Checker: APB handshake, NAK reply and transmit start on channel 0
// Assumes binding to the top module; shadows control and ch0 format writes
`timescale 1ns/1ps
`include "serial_port_regs.svh"

module serial_port_mode_switch_chk #(
    parameter int unsigned clk_hz = 384000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] foreign_frame,
    input wire logic [2:0] txd
);
    // ------------------------------
    // Shadow of software settings
    // ------------------------------
    localparam int unsigned quiet_n = clk_hz / 9600 * 12;
    logic [9:0] ctl_ff;
    logic [15:0] fmt_ff;
    logic [15:0] quiet_ff;
    logic wr;
    logic fit;
    logic free0;
    logic prog0;
    logic calm;
    assign wr = psel && penable && pready && pwrite;
    assign fit = fmt_ff[7:4] >= 4'h3 && fmt_ff[7:4] <= 4'ha && fmt_ff[15:13] == 3'h0;
    assign free0 = ctl_ff[0] && ctl_ff[1] && fit;
    assign prog0 = !ctl_ff[7] && (fmt_ff == 16'h0 || (!ctl_ff[0] && fit));
    // Long idle line; trustworthy only for rates of 9600 and up
    assign calm = 32'(quiet_ff) >= quiet_n;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= 10'h0;
            fmt_ff <= 16'h0;
            quiet_ff <= 16'h0;
        end else begin
            if (wr && paddr == `ADDR_CTRL)
                ctl_ff <= pwdata[9:0];
            if (wr && paddr == `ADDR_CH0_FMT)
                fmt_ff <= pwdata[15:0];
            if (!txd[0])
                quiet_ff <= 16'h0;
            else if (quiet_ff != 16'hffff)
                quiet_ff <= quiet_ff + 16'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wait_s; psel && penable && !pready; endsequence
    sequence hush_s; txd[0] [*8]; endsequence
    sequence send_s; wr && paddr == `ADDR_TXDATA && pwdata[9:8] == 2'h0; endsequence
    ready_wait_a: assert property (wait_s |=> pready)
        else $error("ready missing after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without ready or with data");
    miss_err_a: assert property (wait_s ##0 (paddr > `ADDR_LEGACY_FMT) |=> pslverr)
        else $error("unmapped address not refused");
    hit_ok_a: assert property (wait_s ##0 (paddr <= 8'h30 && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped address refused");
    nak_reply_a: assert property (foreign_frame[0] && prog0 && calm |-> ##[1:8] !txd[0])
        else $error("no reply to foreign traffic");
    free_deaf_a: assert property (foreign_frame[0] && free0 && calm |=> hush_s)
        else $error("reply sent in free mode");
    start_bit_a: assert property (send_s ##0 (free0 && calm) |-> ##[1:8] !txd[0])
        else $error("character not started");
    stop_mute_a: assert property (send_s ##0 (!free0 && calm) |=> hush_s)
        else $error("character sent outside free mode");
endmodule

bind serial_port_mode_switch serial_port_mode_switch_chk #(.clk_hz(clk_hz)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .foreign_frame(foreign_frame), .txd(txd));

//--- testbench/serial_peer_rx.sv
// Far-side serial receiver decoding one txd line by its frame format
// Assumes fmt matches the sender and holds still during a frame
`timescale 1ns/1ps

module serial_peer_rx #(
    parameter int unsigned clk_hz = 192000
) (
    input wire logic pclk,
    input wire logic rxd,
    input wire logic [15:0] fmt,
    output int frames,
    output logic [7:0] last_chr,
    output logic last_ok
);
    int div;
    logic [7:0] c;
    logic ok;
    initial begin
        frames = 0;
        last_chr = 8'h00;
        last_ok = 1'b0;
        forever begin
            @(negedge rxd);
            // Rate doubles per code step from 300
            div = clk_hz / (300 << (fmt[7:4] - 4'h3));
            c = 8'h00;
            repeat (div / 2) @(posedge pclk);
            ok = !rxd;
            for (int i = 0; i < (fmt[0] ? 8 : 7); i++) begin
                repeat (div) @(posedge pclk);
                c[i] = rxd;
            end
            if (fmt[1]) begin
                repeat (div) @(posedge pclk);
                ok = ok && ((^c ^ rxd) != fmt[2]);
            end
            repeat (fmt[3] ? 2 : 1) begin
                repeat (div) @(posedge pclk);
                ok = ok && rxd;
            end
            last_chr = c;
            last_ok = ok;
            frames++;
        end
    end
endmodule

//--- testbench/serial_port_mode_switch_tb_top.sv
// Testbench: register access, mode changeover and framed transmission
// Assumes design, checker bind and peer receiver compiled before it
`timescale 1ns/1ps
`include "serial_port_regs.svh"

module serial_port_mode_switch_tb_top;
    localparam int unsigned hz = 192000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] foreign_frame = 3'h0;
    logic [2:0] txd;
    logic [15:0] peer_fmt [3] = '{16'h0086, 16'h0086, 16'h0086};
    int frm [3];
    logic [7:0] rx_chr [3];
    logic rx_ok [3];
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] seed = 32'd5616;
    logic [9:0] ctl = 10'h0;
    logic [15:0] fm [3] = '{16'h0, 16'h0, 16'h0};
    logic [31:0] q;
    logic e;
    logic [15:0] f;
    logic [7:0] d;
    logic [7:0] term;
    int ch;
    int base;
    // Control and ch0 format pairs, format written first
    logic [25:0] rows [12] = '{26'h0030086, 26'h0000086, 26'h0800086, 26'h0900086,
        26'h0030086, 26'h0010086, 26'h0010000, 26'h0810000, 26'h0910000, 26'h0010086,
        26'h0032086, 26'h0030086};

    serial_port_mode_switch #(.clk_hz(hz)) serial_port_mode_switch_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .foreign_frame(foreign_frame), .txd(txd));
    for (genvar g = 0; g < 3; g++) begin : peer
        serial_peer_rx #(.clk_hz(hz)) serial_peer_rx_i (.pclk(pclk), .rxd(txd[g]),
            .fmt(peer_fmt[g]), .frames(frm[g]), .last_chr(rx_chr[g]), .last_ok(rx_ok[g]));
    end

    // ------------------------------
    // Clock, timeout, helpers
    // ------------------------------
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            results();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [1:0] mode_exp(input logic [9:0] c, input logic [15:0] v,
        input int k);
        logic s;
        s = v[7:4] >= 4'h3 && v[7:4] <= 4'ha && v[15:13] == 3'h0;
        if (c[0] && c[1+k] && s) return 2'h1;
        if (v == 16'h0) return c[7+k] ? 2'h3 : 2'h2;
        if (!c[0] && s) return c[7+k] ? (c[4+k] ? 2'h0 : 2'h3) : 2'h2;
        return 2'h0;
    endfunction
    task automatic results();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        // A slave that never answers ends the run at the report
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic setup(input int c, input logic [15:0] v, input logic [9:0] cv);
        fm[c] = v;
        ctl = cv;
        apb(1'b1, 8'(4 * c), {16'h0, v});
        apb(1'b1, `ADDR_CTRL, {22'h0, cv});
    endtask
    task automatic check_modes();
        for (int c = 0; c < 3; c++) begin
            apb(1'b0, `ADDR_CH0_MODE + 8'(4 * c), 32'h0);
            cmp(q, {30'h0, mode_exp(ctl, fm[c], c)});
        end
    endtask
    task automatic poke(input int c);
        foreign_frame <= 3'(1 << c);
        @(posedge pclk);
        foreign_frame <= 3'h0;
        @(posedge pclk);
    endtask
    task automatic wait_frames(input int c, input int n);
        while (frm[c] < n) @(posedge pclk);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (300) @(posedge pclk);
        apb(1'b0, `ADDR_HDR, 32'h0);
        cmp(q, 32'h02);
        apb(1'b0, `ADDR_TERM, 32'h0);
        cmp(q, 32'h03);
        apb(1'b0, 8'h3c, 32'h0);
        cmp({31'h0, e}, 32'h1);
        check_modes();
        for (int c = 0; c < 3; c++) begin
            base = frm[c];
            poke(c);
            wait_frames(c, base + 1);
            cmp({rx_ok[c], rx_chr[c]}, {1'b1, `NAK_CHAR});
            repeat (300) @(posedge pclk);
        end
        term = 8'(rnd());
        apb(1'b1, `ADDR_TERM, {24'h0, term});
        // Every baud code once, random length, parity and stop bits
        for (int i = 0; i < 8; i++) begin
            ch = i % 3;
            d = 8'(rnd());
            f = {6'h0, (i > 1) ? 2'(i) : 2'h0, 4'(3 + i), 4'(rnd())};
            peer_fmt[ch] = f;
            setup(ch, f, 10'h1 | (10'h2 << ch));
            check_modes();
            repeat (300) @(posedge pclk);
            poke(ch);
            repeat (10) @(posedge pclk);
            base = frm[ch];
            apb(1'b1, `ADDR_TXDATA, {22'h0, 2'(ch), d});
            wait_frames(ch, base + 1 + f[8] + f[9]);
            repeat (20) @(posedge pclk);
            cmp(frm[ch], base + 1 + f[8] + f[9]);
            cmp({rx_ok[ch], rx_chr[ch]}, {1'b1, (f[9] ? term : d) & (f[0] ? 8'hff : 8'h7f)});
            repeat (300) @(posedge pclk);
        end
        foreach (rows[r]) begin
            setup(0, rows[r][15:0], rows[r][25:16]);
            check_modes();
        end
        setup(0, 16'h0086, 10'h0);
        repeat (300) @(posedge pclk);
        apb(1'b1, `ADDR_TXDATA, 32'h41);
        apb(1'b0, `ADDR_ERR, 32'h0);
        cmp(q & 32'h1, 32'h1);
        apb(1'b1, `ADDR_LEGACY_FMT, 32'h0186);
        apb(1'b0, `ADDR_CH1_FMT, 32'h0);
        cmp(q, 32'h0186);
        results();
    end
endmodule
